// ---- vcxo_ctrl_pkg.sv ----
// Package of offsets, field layouts, reset values and scale constants
package vcxo_ctrl_pkg;

  // Register offsets on the configuration port
  localparam logic [7:0] OUT_CTRL_ADDR  = 8'h11;
  localparam logic [7:0] PUMP_CTRL_ADDR = 8'h12;
  localparam logic [7:0] COMMIT_ADDR    = 8'h13;

  // Field positions in the output control register
  localparam int POWER_BIT  = 7;
  localparam int FORMAT_BIT = 6;
  localparam int OSV_BIT    = 5;
  localparam int OFFSET_LSB = 0;

  // Field positions in the pump control register
  localparam int AMP_LSB  = 5;
  localparam int PUMP_LSB = 0;

  // Field reset values
  localparam logic       POWER_RST  = 1'b0;
  localparam logic       FORMAT_RST = 1'b0;
  localparam logic       OSV_RST    = 1'b0;
  localparam logic [4:0] OFFSET_RST = 5'h00;
  localparam logic [1:0] AMP_RST    = 2'h0;
  localparam logic [4:0] PUMP_RST   = 5'h18;

  // Effective output state after startup
  localparam logic       EFF_POWER_RST  = 1'b1;
  localparam logic       EFF_FORMAT_RST = 1'b1;
  localparam logic [1:0] EFF_AMP_RST    = 2'h3;

  // Format encodings
  localparam logic FMT_LVDS   = 1'b0;
  localparam logic FMT_LVPECL = 1'b1;

  // Scale: offset in tenths of a degree, pump in microamps, level in mV
  localparam logic [8:0]  OFFSET_STEP_DDEG = 9'h009;
  localparam logic [12:0] PUMP_STEP_UA     = 13'h00c8;
  localparam logic [9:0]  AMP_LOW_MV       = 10'h0fa;
  localparam logic [9:0]  AMP_MID_MV       = 10'h1f4;
  localparam logic [9:0]  AMP_HIGH_MV      = 10'h2ee;

endpackage : vcxo_ctrl_pkg

// ---- ref_out_stage.sv ----
// Committed power, format and amplitude state of the reference output
`timescale 1ns/1ps
module ref_out_stage
  import vcxo_ctrl_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_clk_en,
  input  wire logic       i_commit,
  input  wire logic       i_power,
  input  wire logic       i_format,
  input  wire logic [1:0] i_amp,
  output logic            o_power,
  output logic            o_format,
  output logic [1:0]      o_amp
);

  logic       power_r, power_nxt;
  logic       format_r, format_nxt;
  logic [1:0] amp_r, amp_nxt;

  // Staged fields only reach the output on commit
  always_comb begin
    power_nxt  = power_r;
    format_nxt = format_r;
    amp_nxt    = amp_r;
    if (i_commit) begin
      power_nxt  = i_power;
      format_nxt = i_format;
      amp_nxt    = i_amp;
    end
  end

  // Startup values differ from the field resets on purpose
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      power_r  <= EFF_POWER_RST;
      format_r <= EFF_FORMAT_RST;
      amp_r    <= EFF_AMP_RST;
    end else if (i_clk_en) begin
      power_r  <= power_nxt;
      format_r <= format_nxt;
      amp_r    <= amp_nxt;
    end
  end

  assign o_power  = power_r;
  assign o_format = format_r;
  assign o_amp    = amp_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence commit_seen;
    i_clk_en && i_commit;
  endsequence

  a_commit_takes_fields: assert property (
    commit_seen |=> (o_power == $past(i_power)) &&
                    (o_format == $past(i_format)) &&
                    (o_amp == $past(i_amp)))
    else $error("Commit did not load the staged fields");

  a_hold_without_commit: assert property (
    !(i_clk_en && i_commit) |=> $stable({o_power, o_format, o_amp}))
    else $error("Output state moved without a commit");

endmodule : ref_out_stage

// ---- vcxo_pll_ctrl.sv ----
// Output and PLL control fields with staged reference output changes
`timescale 1ns/1ps
// Notes on behaviour
// - Committed power field powers reference output up/down
// - Output powered after startup, field reads zero
// - Committed format field selects LVDS or LVPECL
// - LVPECL after startup while format reads zero
// - Offset enable applies selected phase offset
// - Offset equals field times 0.9 degrees
// - Pump current is 200uA times field plus one
// - 750mV after startup while amplitude reads 00
module vcxo_pll_ctrl
  import vcxo_ctrl_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_rd_valid,
  output logic             o_ref_out_power_up,
  output logic             o_ref_out_lvpecl,
  output logic [9:0]       o_ref_out_amp_mv,
  output logic [8:0]       o_pfd_offset_ddeg,
  output logic [12:0]      o_pump_current_ua
);

  // Amplitude code to swing; both formats share one table
  function automatic logic [9:0] amp_mv(input logic [1:0] code);
    case (code)
      2'h0:    amp_mv = AMP_LOW_MV;
      2'h3:    amp_mv = AMP_HIGH_MV;
      default: amp_mv = AMP_MID_MV;
    endcase
  endfunction : amp_mv

  // Phase offset in tenths of a degree, zero when disabled
  function automatic logic [8:0] offset_ddeg(input logic       en,
                                             input logic [4:0] val);
    offset_ddeg = en ? 9'({4'h0, val} * OFFSET_STEP_DDEG) : 9'h000;
  endfunction : offset_ddeg

  // Pump current in microamps
  function automatic logic [12:0] pump_ua(input logic [4:0] val);
    pump_ua = 13'(({8'h00, val} + 13'h0001) * PUMP_STEP_UA);
  endfunction : pump_ua

  logic       power_r, power_nxt;
  logic       format_r, format_nxt;
  logic       osv_r, osv_nxt;
  logic [4:0] offset_r, offset_nxt;
  logic [1:0] amp_r, amp_nxt;
  logic [4:0] pump_r, pump_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rd_valid_r, rd_valid_nxt;
  logic [8:0] offset_ddeg_r, offset_ddeg_nxt;
  logic [12:0] pump_ua_r, pump_ua_nxt;
  logic [9:0] amp_mv_r, amp_mv_nxt;
  logic       commit;
  logic       eff_power;
  logic       eff_format;
  logic [1:0] eff_amp;

  // Any write to the commit address commits; data is ignored
  assign commit = i_wr_en && (i_addr == COMMIT_ADDR);

  // Field writes and read mux; unmapped reads return zero
  always_comb begin
    power_nxt    = power_r;
    format_nxt   = format_r;
    osv_nxt      = osv_r;
    offset_nxt   = offset_r;
    amp_nxt      = amp_r;
    pump_nxt     = pump_r;
    rd_valid_nxt = i_rd_en;
    rdata_nxt    = rdata_r;
    if (i_wr_en) begin
      if (i_addr == OUT_CTRL_ADDR) begin
        power_nxt  = i_wdata[POWER_BIT];
        format_nxt = i_wdata[FORMAT_BIT];
        osv_nxt    = i_wdata[OSV_BIT];
        offset_nxt = i_wdata[OFFSET_LSB +: 5];
      end else if (i_addr == PUMP_CTRL_ADDR) begin
        amp_nxt  = i_wdata[AMP_LSB +: 2];
        pump_nxt = i_wdata[PUMP_LSB +: 5];
      end
    end
    if (i_rd_en) begin
      if (i_addr == OUT_CTRL_ADDR) begin
        rdata_nxt = {power_r, format_r, osv_r, offset_r};
      end else if (i_addr == PUMP_CTRL_ADDR) begin
        rdata_nxt = {1'b0, amp_r, pump_r};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // Analog settings derived from fields and committed state
  always_comb begin
    offset_ddeg_nxt = offset_ddeg(osv_r, offset_r);
    pump_ua_nxt     = pump_ua(pump_r);
    amp_mv_nxt      = amp_mv(eff_amp);
  end

  // Register stage; clock enable freezes everything
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      power_r       <= POWER_RST;
      format_r      <= FORMAT_RST;
      osv_r         <= OSV_RST;
      offset_r      <= OFFSET_RST;
      amp_r         <= AMP_RST;
      pump_r        <= PUMP_RST;
      rdata_r       <= 8'h00;
      rd_valid_r    <= 1'b0;
      offset_ddeg_r <= 9'h000;
      pump_ua_r     <= 13'h0000;
      amp_mv_r      <= AMP_HIGH_MV;
    end else if (i_clk_en) begin
      power_r       <= power_nxt;
      format_r      <= format_nxt;
      osv_r         <= osv_nxt;
      offset_r      <= offset_nxt;
      amp_r         <= amp_nxt;
      pump_r        <= pump_nxt;
      rdata_r       <= rdata_nxt;
      rd_valid_r    <= rd_valid_nxt;
      offset_ddeg_r <= offset_ddeg_nxt;
      pump_ua_r     <= pump_ua_nxt;
      amp_mv_r      <= amp_mv_nxt;
    end
  end

  // Committed output state lives apart from the readable fields
  ref_out_stage u_stage (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_clk_en  (i_clk_en),
    .i_commit  (commit),
    .i_power   (power_r),
    .i_format  (format_r),
    .i_amp     (amp_r),
    .o_power   (eff_power),
    .o_format  (eff_format),
    .o_amp     (eff_amp)
  );

  assign o_rdata            = rdata_r;
  assign o_rd_valid         = rd_valid_r;
  assign o_ref_out_power_up = eff_power;
  assign o_ref_out_lvpecl   = eff_format;
  assign o_ref_out_amp_mv   = amp_mv_r;
  assign o_pfd_offset_ddeg  = offset_ddeg_r;
  assign o_pump_current_ua  = pump_ua_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence reset_release;
    !$past(i_resetn) ##0 i_resetn;
  endsequence

  a_startup_output_state: assert property (
    reset_release |-> o_ref_out_power_up && o_ref_out_lvpecl &&
                      !power_r && !format_r && (amp_r == 2'h0))
    else $error("Startup output state or field reset wrong");

  // A commit on the release edge may legally move the amplitude away
  a_startup_amp_high: assert property (
    reset_release ##0 !commit ##1 i_clk_en |=>
      o_ref_out_amp_mv == AMP_HIGH_MV)
    else $error("Startup amplitude not at the high setting");

  a_offset_disabled_zero: assert property (
    i_clk_en && !osv_r |=> o_pfd_offset_ddeg == 9'h000)
    else $error("Offset applied while disabled");

  a_offset_scale: assert property (
    i_clk_en && osv_r && (offset_r == 5'h1f) |=>
      o_pfd_offset_ddeg == 9'd279)
    else $error("Full-scale offset is not 27.9 degrees");

  a_pump_scale: assert property (
    i_clk_en |=> o_pump_current_ua ==
      13'(({8'h00, $past(pump_r)} + 13'h0001) * 13'd200))
    else $error("Pump current does not follow its field");

  a_pump_reset_value: assert property (
    reset_release |-> pump_r == 5'h18)
    else $error("Pump field reset value wrong");

  a_amp_after_commit: assert property (
    i_clk_en && commit && (amp_r == 2'h0) ##1 i_clk_en |=>
      o_ref_out_amp_mv == 10'd250)
    else $error("Amplitude code 00 did not give 250mV");

  a_field_write_no_effect: assert property (
    i_clk_en && i_wr_en && (i_addr == OUT_CTRL_ADDR) |=>
      $stable({o_ref_out_power_up, o_ref_out_lvpecl}))
    else $error("Field write changed output without commit");

  a_read_back_fields: assert property (
    i_clk_en && i_rd_en && (i_addr == OUT_CTRL_ADDR) |=>
      o_rd_valid && o_rdata == $past({power_r, format_r, osv_r, offset_r}))
    else $error("Output control read-back wrong");

endmodule : vcxo_pll_ctrl

// ---- vcxo_pll_ctrl_tb.sv ----
// Self-checking bench for the output and PLL control fields
`timescale 1ns/1ps
module vcxo_pll_ctrl_tb;
  import vcxo_ctrl_pkg::*;

  typedef struct {
    logic [7:0]  ctl;
    logic [7:0]  pmp;
    logic        pwr;
    logic        pecl;
    logic [9:0]  mv;
    logic [8:0]  ofs;
    logic [12:0] ua;
  } row_s;

  logic        sys_clk;
  logic        resetn;
  logic        clk_en;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rd_valid;
  logic        pwr;
  logic        pecl;
  logic [9:0]  mv;
  logic [8:0]  ofs;
  logic [12:0] ua;
  logic        p;
  logic        f;
  logic [9:0]  m;
  int          err_total;
  int          total_checks;
  row_s        rows [4];

  vcxo_pll_ctrl u_dut (
    .i_sys_clk          (sys_clk),
    .i_resetn           (resetn),
    .i_clk_en           (clk_en),
    .i_wr_en            (wr_en),
    .i_rd_en            (rd_en),
    .i_addr             (addr),
    .i_wdata            (wdata),
    .o_rdata            (rdata),
    .o_rd_valid         (rd_valid),
    .o_ref_out_power_up (pwr),
    .o_ref_out_lvpecl   (pecl),
    .o_ref_out_amp_mv   (mv),
    .o_pfd_offset_ddeg  (ofs),
    .o_pump_current_ua  (ua)
  );

  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Verdict and end of run, shared with the watchdog
  task automatic summarize;
    $display("Checks: %0d, errors: %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // Four-state compare, so an unknown never counts as a match
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Inputs move 1 ns after the edge to stay clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  // Idle cycle after each write, so the strobe never re-rises in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    step(1);
    wr_en = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_en = 1'b1;
    addr  = a;
    step(1);
    rd_en = 1'b0;
    chk(rd_valid, 1'b1);
    chk(rdata, exp);
    step(1);
    chk(rd_valid, 1'b0);
  endtask : rd

  task automatic outs(input logic p0, input logic f0, input logic [9:0] m0);
    chk(pwr, p0);
    chk(pecl, f0);
    chk(mv, m0);
  endtask : outs

  // Startup state differs from the field reset values
  task automatic startup;
    outs(EFF_POWER_RST, EFF_FORMAT_RST, 10'h2ee);
    chk(ofs, 9'h000);
    chk(ua, 13'h1388);
    rd(OUT_CTRL_ADDR, 8'h00);
    rd(PUMP_CTRL_ADDR, 8'h18);
  endtask : startup

  // Hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    wr_en  = 1'b0;
    rd_en  = 1'b0;
    addr   = 8'h00;
    wdata  = 8'h00;
    err_total    = 0;
    total_checks = 0;
    // Control byte, pump byte, then the outputs they should give
    rows[0] = '{8'hbf, 8'h00, 1'b1, 1'b0, 10'h0fa, 9'h117, 13'h00c8};
    rows[1] = '{8'h41, 8'hbf, 1'b0, 1'b1, 10'h1f4, 9'h000, 13'h1900};
    rows[2] = '{8'he1, 8'h45, 1'b1, 1'b1, 10'h1f4, 9'h009, 13'h04b0};
    rows[3] = '{8'h00, 8'h78, 1'b0, 1'b0, 10'h2ee, 9'h000, 13'h1388};
    step(10);
    resetn = 1'b1;
    step(2);
    startup();
    p = EFF_POWER_RST;
    f = EFF_FORMAT_RST;
    m = EFF_AMP_RST == 2'h3 ? 10'h2ee : 10'h000;
    foreach (rows[i]) begin
      wr(OUT_CTRL_ADDR, rows[i].ctl);
      wr(PUMP_CTRL_ADDR, rows[i].pmp);
      step(1);
      outs(p, f, m);
      chk(ofs, rows[i].ofs);
      chk(ua, rows[i].ua);
      rd(OUT_CTRL_ADDR, rows[i].ctl);
      rd(PUMP_CTRL_ADDR, rows[i].pmp & 8'h7f);
      wr(COMMIT_ADDR, 8'h00);
      step(1);
      outs(rows[i].pwr, rows[i].pecl, rows[i].mv);
      p = rows[i].pwr;
      f = rows[i].pecl;
      m = rows[i].mv;
    end
    // Frozen clock enable: neither field write nor commit lands
    clk_en = 1'b0;
    wr(OUT_CTRL_ADDR, 8'hc0);
    wr(COMMIT_ADDR, 8'h00);
    clk_en = 1'b1;
    step(1);
    outs(p, f, m);
    rd(OUT_CTRL_ADDR, rows[3].ctl);
    // Field change without commit keeps the old output state
    wr(OUT_CTRL_ADDR, 8'hc0);
    step(2);
    outs(p, f, m);
    // Unmapped write is dropped, commit and unmapped reads give zero
    wr(8'h20, 8'hff);
    rd(COMMIT_ADDR, 8'h00);
    rd(8'h20, 8'h00);
    rd(PUMP_CTRL_ADDR, 8'h78);
    wr(PUMP_CTRL_ADDR, 8'h00);
    wr(COMMIT_ADDR, 8'h00);
    step(1);
    outs(1'b1, 1'b1, 10'h0fa);
    // Leave state unlike startup, so the reset below must undo it
    wr(OUT_CTRL_ADDR, 8'h00);
    wr(COMMIT_ADDR, 8'h00);
    step(1);
    outs(1'b0, 1'b0, 10'h0fa);
    chk(ua, 13'h00c8);
    // Second reset in mid-run restores the startup state
    resetn = 1'b0;
    step(3);
    resetn = 1'b1;
    step(2);
    startup();
    summarize();
  end

endmodule : vcxo_pll_ctrl_tb
